// >>> design/mosf_formatter.sv
// Output record framer, byte FIFO and service request status byte
// Summary of operation
// - Switch picks comma (default) or CR LF as field delimiter.
// - In CR LF mode each field ends with carriage return then line feed.
// - Primary and secondary data always sent; parameter data only after its command.
// - Status, function and deviation fields are one or two uppercase letters.
// - Range sent as exponent E-12 up to E+06.
// - Status character: N normal, O overflow, U uncalibrated.
// - Primary function is one of thirteen two-letter codes.
// - Deviation character: N normal, D absolute, P percent.
// - Secondary function codes, UM when no secondary measurement.
// - Parameter unit: K kHz, V volts, M mA, R reference.
// - Service request raised while status bit 1,2,3,4 or 6 is set.
// - Bit 7 shows request pending; bit 8 always zero.
// - Bit 1 on new data with data ready on, or self-test pass with self-test enabled.
// - Bit 2 on an invalid remote program code.
// - Bit 3 on an illegal remotely programmed setting.
// - Bit 4 on a trigger before the last measurement ended.
// - Bit 6 on hardware fault or failed enabled self-test.
// - Bit 5 while sweep or self-test or zeroing runs; cleared by trigger; no request.
// - Order: primary fields, delimiter, secondary fields, then delimiter and parameter if enabled, terminator.
`timescale 1ns/1ps
`include "mosf_defs.svh"

module mosf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `MOSF_FIFO_DEPTH
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;

  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    in_ready_o = !full;
    out_valid_o = !empty;
    out_data_o = mem[rd_ptr[AW-1:0]];
    push = in_valid_i && !full;
    pop = out_ready_i && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage carries no reset so it maps onto plain RAM
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule : mosf_fifo

module mosf_formatter
  import mosf_pkg::*;
#(
  parameter int VAL_LEN = `MOSF_VAL_LEN
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic delim_crlf_i,
  input wire logic test_parameter_output_command_i,
  input wire logic param_out_off_i,
  input wire logic start_i,
  input wire mosf_stat_e stat_a_i,
  input wire mosf_fna_e fn_a_i,
  input wire mosf_dev_e dev_a_i,
  input wire logic [8*VAL_LEN-1:0] val_a_i,
  input wire mosf_rng_e rng_a_i,
  input wire mosf_stat_e stat_b_i,
  input wire mosf_fnb_e fn_b_i,
  input wire mosf_dev_e dev_b_i,
  input wire logic [8*VAL_LEN-1:0] val_b_i,
  input wire mosf_rng_e rng_b_i,
  input wire mosf_unit_e unit_c_i,
  input wire logic [8*VAL_LEN-1:0] val_c_i,
  output logic busy_o,
  output logic [7:0] out_byte_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  input wire logic data_ready_en_i,
  input wire logic selftest_en_i,
  input wire logic meas_done_i,
  input wire logic selftest_pass_i,
  input wire logic selftest_fail_i,
  input wire logic bad_code_i,
  input wire logic illegal_set_i,
  input wire logic early_trig_i,
  input wire logic hw_fault_i,
  input wire logic activity_i,
  input wire logic trigger_i,
  input wire logic spoll_i,
  output logic [7:0] service_request_status_o,
  output logic srq_o
);
  localparam int SEG_LEN = `MOSF_HEAD_LEN + VAL_LEN + `MOSF_EXP_LEN;
  localparam int IW = $clog2(SEG_LEN + 1);
  localparam logic [7:0] REASONS = `MOSF_SB_REASONS;

  mosf_state_e state, next_state;
  logic [IW-1:0] idx, next_idx;
  logic sw_meta, sw_sync;
  logic crlf_q, next_crlf_q, par_q, next_par_q, par_en, next_par_en;
  logic [7:0] st_a, st_b, dv_a, dv_b, next_st_a, next_st_b, next_dv_a, next_dv_b;
  logic [15:0] fn_a, fn_b, next_fn_a, next_fn_b;
  logic [8*VAL_LEN-1:0] v_a, v_b, v_c, next_v_a, next_v_b, next_v_c;
  logic [2:0] rg_a, rg_b, next_rg_a, next_rg_b;
  logic [7:0] u_c, next_u_c, byte_d;
  logic push, last, fifo_in_ready, fifo_out_valid, load;
  logic [7:0] fifo_out_data, stat, next_stat, next_out_byte;
  logic next_out_valid;

  // Segment byte by index: status, function, deviation, value, then exponent text from the range code
  function automatic logic [7:0] seg_byte(input logic [IW-1:0] i, input logic [7:0] st,
      input logic [15:0] fn, input logic [7:0] dv, input logic [8*VAL_LEN-1:0] v,
      input logic [2:0] rg);
    logic [3:0] mag;
    int k;
    mag = (rg < `MOSF_RG_UNITY) ? 4'((`MOSF_RG_UNITY - rg) * `MOSF_EXP_STEP)
                                : 4'((rg - `MOSF_RG_UNITY) * `MOSF_EXP_STEP);
    k = int'(i) - `MOSF_HEAD_LEN;
    if (i == IW'(0)) begin
      seg_byte = st;
    end else if (i == IW'(1)) begin
      seg_byte = fn[15:8];
    end else if (i == IW'(2)) begin
      seg_byte = fn[7:0];
    end else if (i == IW'(3)) begin
      seg_byte = dv;
    end else if (k < VAL_LEN) begin
      seg_byte = v[8*(VAL_LEN-1-k) +: 8];
    end else if (k == VAL_LEN) begin
      seg_byte = `MOSF_CH_E;
    end else if (k == VAL_LEN + 1) begin
      seg_byte = (rg < `MOSF_RG_UNITY) ? `MOSF_CH_MINUS : `MOSF_CH_PLUS;
    end else if (k == VAL_LEN + 2) begin
      seg_byte = (mag >= `MOSF_TEN) ? `MOSF_CH_ZERO + 8'h01 : `MOSF_CH_ZERO;
    end else begin
      seg_byte = `MOSF_CH_ZERO | 8'((mag >= `MOSF_TEN) ? mag - `MOSF_TEN : mag);
    end
  endfunction : seg_byte

  // Delimiter switch is a panel pin: two flops before use
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sw_meta <= 1'b0;
      sw_sync <= 1'b0;
    end else begin
      sw_meta <= delim_crlf_i;
      sw_sync <= sw_meta;
    end
  end

  // Fields are frozen at start so a record never mixes two measurements
  always_comb begin
    next_st_a = st_a; next_fn_a = fn_a; next_dv_a = dv_a; next_v_a = v_a;
    next_rg_a = rg_a; next_st_b = st_b; next_fn_b = fn_b; next_dv_b = dv_b;
    next_v_b = v_b; next_rg_b = rg_b; next_u_c = u_c; next_v_c = v_c;
    next_crlf_q = crlf_q; next_par_q = par_q;
    next_par_en = test_parameter_output_command_i || (par_en && !param_out_off_i);
    if (state == S_IDLE && start_i) begin
      next_st_a = stat_a_i; next_fn_a = fn_a_i; next_dv_a = dev_a_i;
      next_v_a = val_a_i; next_rg_a = rng_a_i;
      next_st_b = stat_b_i; next_fn_b = fn_b_i; next_dv_b = dev_b_i;
      next_v_b = val_b_i; next_rg_b = rng_b_i;
      next_u_c = unit_c_i; next_v_c = val_c_i;
      next_crlf_q = sw_sync;
      next_par_q = par_en;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_a <= '0; fn_a <= '0; dv_a <= '0; v_a <= '0; rg_a <= '0;
      st_b <= '0; fn_b <= '0; dv_b <= '0; v_b <= '0; rg_b <= '0;
      u_c <= '0; v_c <= '0; crlf_q <= 1'b0; par_q <= 1'b0; par_en <= 1'b0;
    end else begin
      st_a <= next_st_a; fn_a <= next_fn_a; dv_a <= next_dv_a; v_a <= next_v_a;
      rg_a <= next_rg_a; st_b <= next_st_b; fn_b <= next_fn_b; dv_b <= next_dv_b;
      v_b <= next_v_b; rg_b <= next_rg_b; u_c <= next_u_c; v_c <= next_v_c;
      crlf_q <= next_crlf_q; par_q <= next_par_q; par_en <= next_par_en;
    end
  end

  // Record sequencer: one byte per cycle while the FIFO has room
  always_comb begin
    next_state = state;
    next_idx = idx;
    push = 1'b0;
    last = 1'b0;
    byte_d = 8'h00;
    case (state)
      S_IDLE: begin
        if (start_i) begin
          next_state = S_A;
        end
      end
      S_A: begin
        push = 1'b1;
        byte_d = seg_byte(idx, st_a, fn_a, dv_a, v_a, rg_a);
        last = (idx == IW'(SEG_LEN - 1));
      end
      S_B: begin
        push = 1'b1;
        byte_d = seg_byte(idx, st_b, fn_b, dv_b, v_b, rg_b);
        last = (idx == IW'(SEG_LEN - 1));
      end
      S_DA, S_DB: begin
        push = 1'b1;
        if (crlf_q) begin
          byte_d = (idx == IW'(0)) ? `MOSF_CH_CR : `MOSF_CH_LF;
        end else begin
          byte_d = `MOSF_CH_COMMA;
        end
        last = !crlf_q || (idx == IW'(1));
      end
      S_C: begin
        push = 1'b1;
        byte_d = (idx == IW'(0)) ? u_c : v_c[8*(VAL_LEN-int'(idx)) +: 8];
        last = (idx == IW'(VAL_LEN));
      end
      S_END: begin
        push = 1'b1;
        byte_d = (idx == IW'(0)) ? `MOSF_CH_CR : `MOSF_CH_LF;
        last = (idx == IW'(1));
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (push && fifo_in_ready) begin
      next_idx = last ? '0 : idx + 1'b1;
      if (last) begin
        case (state)
          S_A: next_state = S_DA;
          S_DA: next_state = S_B;
          S_B: next_state = par_q ? S_DB : S_END;
          S_DB: next_state = S_C;
          S_C: next_state = S_END;
          default: next_state = S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      idx <= '0;
      busy_o <= 1'b0;
    end else begin
      state <= next_state;
      idx <= next_idx;
      busy_o <= (next_state != S_IDLE);
    end
  end

  mosf_fifo #(.WIDTH(8), .DEPTH(`MOSF_FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .in_data_i(byte_d),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(load)
  );

  // Output register keeps the byte port glitch free
  always_comb begin
    load = fifo_out_valid && (!out_valid_o || out_ready_i);
    next_out_valid = load || (out_valid_o && !out_ready_i);
    next_out_byte = load ? fifo_out_data : out_byte_o;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_o <= 1'b0;
      out_byte_o <= 8'h00;
    end else begin
      out_valid_o <= next_out_valid;
      out_byte_o <= next_out_byte;
    end
  end

  // Status byte; a new event in the poll cycle survives the poll
  always_comb begin
    next_stat = stat;
    if (spoll_i) begin
      next_stat = stat & ~REASONS;
    end
    if ((meas_done_i && data_ready_en_i) || (selftest_pass_i && selftest_en_i)) begin
      next_stat[`MOSF_SB_DRDY] = 1'b1;
    end
    if (bad_code_i) begin
      next_stat[`MOSF_SB_BADCODE] = 1'b1;
    end
    if (illegal_set_i) begin
      next_stat[`MOSF_SB_ILLEGAL] = 1'b1;
    end
    if (early_trig_i) begin
      next_stat[`MOSF_SB_EARLY] = 1'b1;
    end
    if (hw_fault_i || (selftest_fail_i && selftest_en_i)) begin
      next_stat[`MOSF_SB_FAULT] = 1'b1;
    end
    next_stat[`MOSF_SB_BUSY] = activity_i || (stat[`MOSF_SB_BUSY] && !trigger_i);
    next_stat[`MOSF_SB_RQS] = |(next_stat & REASONS);
    next_stat[`MOSF_SB_ZERO] = 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat <= `MOSF_STAT_RST;
    end else begin
      stat <= next_stat;
    end
  end

  assign service_request_status_o = stat;
  assign srq_o = stat[`MOSF_SB_RQS];

  a_srq_reason: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    $rose(srq_o) |-> $past(meas_done_i) || $past(selftest_pass_i) || $past(bad_code_i)
    || $past(illegal_set_i) || $past(early_trig_i) || $past(hw_fault_i)
    || $past(selftest_fail_i)) else $error("request without a reason event");
  a_bit8_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    !service_request_status_o[7]) else $error("bit 8 not zero");
  a_busy_no_srq: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    activity_i && !srq_o && !meas_done_i && !selftest_pass_i && !bad_code_i && !illegal_set_i
    && !early_trig_i && !hw_fault_i && !selftest_fail_i |=> !srq_o)
    else $error("activity raised request");
  a_drdy_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    meas_done_i && data_ready_en_i |=> stat[0] && srq_o) else $error("no data ready");
  a_badcode_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    bad_code_i |=> stat[1] && srq_o) else $error("bad code not flagged");
  a_illegal_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    illegal_set_i |=> stat[2]) else $error("illegal setting not flagged");
  a_early_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    early_trig_i |=> stat[3]) else $error("early trigger not flagged");
  a_fault_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    hw_fault_i || (selftest_fail_i && selftest_en_i) |=> stat[5])
    else $error("fault not flagged");
  a_trig_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    trigger_i && !activity_i |=> !stat[4]) else $error("activity bit kept");
  a_poll_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    spoll_i && !meas_done_i && !selftest_pass_i && !bad_code_i && !illegal_set_i
    && !early_trig_i && !hw_fault_i && !selftest_fail_i |=> !srq_o)
    else $error("poll left request");
  a_comma_delim: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    state == S_DA && !crlf_q |-> byte_d == `MOSF_CH_COMMA) else $error("bad comma");
  a_crlf_pair: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    state == S_DA && crlf_q && idx == IW'(0) && fifo_in_ready |=> byte_d == `MOSF_CH_LF)
    else $error("CR without LF");
  a_param_skip: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    state == S_B && last && fifo_in_ready |=> state == (par_q ? S_DB : S_END))
    else $error("parameter field misplaced");

  c_crlf_record: cover property (@(posedge clk_sys_i) state == S_DB && crlf_q);
  c_param_record: cover property (@(posedge clk_sys_i) state == S_C && idx == IW'(VAL_LEN));
  c_fifo_stall: cover property (@(posedge clk_sys_i) push && !fifo_in_ready);
  c_poll_event: cover property (@(posedge clk_sys_i) spoll_i && bad_code_i);
endmodule : mosf_formatter

// >>> design/mosf_defs.svh
// Constants for the measurement output and status formatter
`ifndef MOSF_DEFS_SVH
`define MOSF_DEFS_SVH
`define MOSF_CH_CR 8'h0D
`define MOSF_CH_LF 8'h0A
`define MOSF_CH_COMMA 8'h2C
`define MOSF_CH_E 8'h45
`define MOSF_CH_PLUS 8'h2B
`define MOSF_CH_MINUS 8'h2D
`define MOSF_CH_ZERO 8'h30
`define MOSF_HEAD_LEN 4
`define MOSF_EXP_LEN 4
`define MOSF_RG_UNITY 3'h4
`define MOSF_EXP_STEP 4'h3
`define MOSF_TEN 4'hA
`define MOSF_SB_DRDY 0
`define MOSF_SB_BADCODE 1
`define MOSF_SB_ILLEGAL 2
`define MOSF_SB_EARLY 3
`define MOSF_SB_BUSY 4
`define MOSF_SB_FAULT 5
`define MOSF_SB_RQS 6
`define MOSF_SB_ZERO 7
`define MOSF_SB_REASONS 8'h2F
`define MOSF_STAT_RST 8'h00
`define MOSF_FIFO_DEPTH 16
`define MOSF_VAL_LEN 8
`endif

// >>> design/mosf_pkg.sv
// Types of the measurement output and status formatter
package mosf_pkg;
  typedef enum logic [7:0] {
    ST_NORMAL = 8'h4E, ST_OVER = 8'h4F, ST_UNCAL = 8'h55
  } mosf_stat_e;
  typedef enum logic [15:0] {
    FA_Z = 16'h5A46, FA_Y = 16'h5946, FA_R = 16'h5246, FA_G = 16'h4746,
    FA_LS = 16'h4C53, FA_LP = 16'h4C50, FA_CS = 16'h4353, FA_CP = 16'h4350,
    FA_BA = 16'h4241, FA_AV = 16'h4156, FA_BV = 16'h4256, FA_AM = 16'h414D,
    FA_BM = 16'h424D
  } mosf_fna_e;
  typedef enum logic [15:0] {
    FB_TD = 16'h5444, FB_TR = 16'h5452, FB_X = 16'h5846, FB_B = 16'h4246,
    FB_Q = 16'h5146, FB_D = 16'h4446, FB_R = 16'h5246, FB_G = 16'h4746,
    FB_GD = 16'h4744, FB_NONE = 16'h554D
  } mosf_fnb_e;
  typedef enum logic [7:0] {
    DV_NORMAL = 8'h4E, DV_ABS = 8'h44, DV_PCT = 8'h50
  } mosf_dev_e;
  typedef enum logic [7:0] {
    UC_KHZ = 8'h4B, UC_VOLT = 8'h56, UC_MAMP = 8'h4D, UC_REF = 8'h52
  } mosf_unit_e;
  typedef enum logic [2:0] {
    RG_PICO = 3'h0, RG_NANO = 3'h1, RG_MICRO = 3'h2, RG_MILLI = 3'h3,
    RG_UNITY = 3'h4, RG_KILO = 3'h5, RG_MEGA = 3'h6
  } mosf_rng_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_A = 3'b001, S_DA = 3'b010, S_B = 3'b011,
    S_DB = 3'b100, S_C = 3'b101, S_END = 3'b110
  } mosf_state_e;
endpackage : mosf_pkg

// >>> testbench/mosf_sink.sv
// Bus controller model that takes record bytes, promptly or with long stalls
`timescale 1ns/1ps
module mosf_sink (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic slow_i,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  output logic ready_o
);
  logic [2:0] cnt;
  logic [7:0] got[$];
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 3'h0;
      ready_o <= 1'b0;
    end else begin
      if (valid_i && ready_o) begin
        got.push_back(byte_i);
      end
      cnt <= cnt + 3'h1;
      // One byte in eight when slow, so a record overruns the 16-word FIFO
      ready_o <= !slow_i || (cnt == 3'h7);
    end
  end
endmodule : mosf_sink

// >>> testbench/mosf_formatter_tb.sv
// Self-checking bench for the output record framer and status byte
`timescale 1ns/1ps
module mosf_formatter_tb
  import mosf_pkg::*;
;
  localparam int VLEN = 8;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 0, delim = 0, pcmd = 0, poff = 0, slow = 0, spoll = 0;
  logic drdy_en = 0, st_en = 0, meas = 0, st_pass = 0, st_fail = 0;
  logic bad = 0, illegal = 0, early = 0, fault = 0, act = 0, trig = 0;
  mosf_stat_e stat_a = ST_NORMAL, stat_b = ST_NORMAL;
  mosf_fna_e fn_a = FA_Z;
  mosf_fnb_e fn_b = FB_TD;
  mosf_dev_e dev_a = DV_NORMAL, dev_b = DV_NORMAL;
  mosf_rng_e rng_a = RG_PICO, rng_b = RG_PICO;
  mosf_unit_e unit_c = UC_KHZ;
  logic [8*VLEN-1:0] val_a = '0, val_b = '0, val_c = '0;
  logic busy, ovalid, ordy, srq;
  logic [7:0] obyte, stat;
  int fails = 0, total_checks = 0, cycles = 0;
  logic [7:0] exp_q[$];
  mosf_stat_e st_t[3] = '{ST_NORMAL, ST_OVER, ST_UNCAL};
  mosf_fna_e fa_t[13] = '{FA_Z, FA_Y, FA_R, FA_G, FA_LS, FA_LP, FA_CS, FA_CP,
                          FA_BA, FA_AV, FA_BV, FA_AM, FA_BM};
  mosf_fnb_e fb_t[10] = '{FB_TD, FB_TR, FB_X, FB_B, FB_Q, FB_D, FB_R, FB_G, FB_GD, FB_NONE};
  mosf_dev_e dv_t[3] = '{DV_NORMAL, DV_ABS, DV_PCT};
  mosf_unit_e un_t[4] = '{UC_KHZ, UC_VOLT, UC_MAMP, UC_REF};
  mosf_rng_e rg_t[7] = '{RG_PICO, RG_NANO, RG_MICRO, RG_MILLI, RG_UNITY, RG_KILO, RG_MEGA};
  logic [7:0] ev_exp[8] = '{8'h41, 8'h00, 8'h41, 8'h60, 8'h60, 8'h42, 8'h44, 8'h48};

  always #2.5 clk = ~clk;

  mosf_formatter #(.VAL_LEN(VLEN)) i_dut (
    .clk_sys_i(clk), .rst_b_i(rst_b), .delim_crlf_i(delim),
    .test_parameter_output_command_i(pcmd), .param_out_off_i(poff), .start_i(start),
    .stat_a_i(stat_a), .fn_a_i(fn_a), .dev_a_i(dev_a), .val_a_i(val_a), .rng_a_i(rng_a),
    .stat_b_i(stat_b), .fn_b_i(fn_b), .dev_b_i(dev_b), .val_b_i(val_b), .rng_b_i(rng_b),
    .unit_c_i(unit_c), .val_c_i(val_c), .busy_o(busy), .out_byte_o(obyte),
    .out_valid_o(ovalid), .out_ready_i(ordy), .data_ready_en_i(drdy_en),
    .selftest_en_i(st_en), .meas_done_i(meas), .selftest_pass_i(st_pass),
    .selftest_fail_i(st_fail), .bad_code_i(bad), .illegal_set_i(illegal),
    .early_trig_i(early), .hw_fault_i(fault), .activity_i(act), .trigger_i(trig),
    .spoll_i(spoll), .service_request_status_o(stat), .srq_o(srq)
  );

  mosf_sink i_sink (
    .clk_sys_i(clk), .rst_b_i(rst_b), .slow_i(slow), .byte_i(obyte),
    .valid_i(ovalid), .ready_o(ordy)
  );

  task automatic end_sim;
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    cycles <= cycles + 1;
    // Thirteen records with slow drain take well under this
    if (cycles == 40000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic add_disp(input logic [7:0] s, input logic [15:0] f, input logic [7:0] d,
                          input logic [8*VLEN-1:0] v, input int r);
    int e;
    e = r * 3 - 12;
    exp_q.push_back(s);
    exp_q.push_back(f[15:8]);
    exp_q.push_back(f[7:0]);
    exp_q.push_back(d);
    for (int j = VLEN - 1; j >= 0; j--) exp_q.push_back(v[8*j+:8]);
    exp_q.push_back(8'h45);
    exp_q.push_back(e < 0 ? 8'h2D : 8'h2B);
    if (e < 0) e = -e;
    exp_q.push_back(8'(8'h30 + e / 10));
    exp_q.push_back(8'(8'h30 + e % 10));
  endtask : add_disp

  task automatic add_delim(input logic crlf);
    if (crlf) begin
      exp_q.push_back(8'h0D);
      exp_q.push_back(8'h0A);
    end else begin
      exp_q.push_back(8'h2C);
    end
  endtask : add_delim

  task automatic rec(input int i);
    logic pon;
    int w;
    // Case 4 raises both commands together; the enabling one must win
    pon = i[1] || i == 4;
    @(posedge clk);
    stat_a <= st_t[i % 3];
    stat_b <= st_t[(i + 1) % 3];
    fn_a <= fa_t[i];
    fn_b <= fb_t[i % 10];
    dev_a <= dv_t[i % 3];
    dev_b <= dv_t[(i + 2) % 3];
    rng_a <= rg_t[i % 7];
    rng_b <= rg_t[(i + 3) % 7];
    unit_c <= un_t[i % 4];
    val_a <= {"-0.0045", 8'(8'h30 + i)};
    val_b <= {"+123.45", 8'(8'h30 + i)};
    val_c <= {"0010.00", 8'(8'h30 + i)};
    delim <= i[0];
    slow <= i[0];
    pcmd <= pon;
    poff <= !i[1];
    @(posedge clk);
    pcmd <= 1'b0;
    poff <= 1'b0;
    repeat (3) @(posedge clk);
    // Held for three edges: the later two fall while busy and are ignored
    start <= 1'b1;
    repeat (3) @(posedge clk);
    start <= 1'b0;
    exp_q.delete();
    add_disp(stat_a, fn_a, dev_a, val_a, int'(rng_a));
    add_delim(delim);
    add_disp(stat_b, fn_b, dev_b, val_b, int'(rng_b));
    if (pon) begin
      add_delim(delim);
      exp_q.push_back(unit_c);
      for (int j = VLEN - 1; j >= 0; j--) exp_q.push_back(val_c[8*j+:8]);
    end
    add_delim(1'b1);
    w = 0;
    while ((busy !== 1'b0 || i_sink.got.size() < exp_q.size()) && w < 3000) begin
      @(posedge clk);
      w++;
    end
    repeat (40) @(posedge clk);
    chk(8'(i_sink.got.size()), 8'(exp_q.size()));
    foreach (exp_q[j]) begin
      chk(i_sink.got[j], exp_q[j]);
    end
    i_sink.got.delete();
  endtask : rec

  task automatic pulse(input int k);
    @(posedge clk);
    meas <= (k == 0 || k == 1);
    st_pass <= (k == 2);
    st_fail <= (k == 3);
    fault <= (k == 4);
    bad <= (k == 5);
    illegal <= (k == 6);
    early <= (k == 7);
    trig <= (k == 8);
    spoll <= (k == 9);
    @(posedge clk);
    {meas, st_pass, st_fail, fault, bad, illegal, early, trig, spoll} <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk(stat, 8'h00);
    chk({7'h00, busy}, 8'h00);
    for (int i = 0; i < 13; i++) rec(i);
    // Self-test outcomes are ignored while self-test is off
    pulse(2);
    chk(stat, 8'h00);
    pulse(3);
    chk(stat, 8'h00);
    @(posedge clk);
    st_en <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      drdy_en <= (k != 1);
      pulse(k);
      chk(stat, ev_exp[k]);
      chk({7'h00, srq}, {7'h00, ev_exp[k][6]});
      pulse(9);
      chk({stat[7:5], stat[3:0], srq}, 8'h00);
    end
    @(posedge clk);
    act <= 1'b1;
    repeat (3) @(posedge clk);
    act <= 1'b0;
    pulse(9);
    chk(stat, 8'h10);
    chk({7'h00, srq}, 8'h00);
    pulse(8);
    chk(stat, 8'h00);
    end_sim();
  end
endmodule : mosf_formatter_tb
